// >>> common/bus_cycle_pkg.sv
package bus_cycle_pkg;

  // Clock period of the block, in ns
  localparam int CLK_NS = 4;

  // Width of the interval counters, enough for the reply timeout
  localparam int CNT_W = 12;
  typedef logic [CNT_W-1:0] cnt_t;

  // Bus widths
  localparam int DAL_W = 18;
  localparam int WORD_W = 16;
  localparam int BYTE_W = 8;
  localparam int VEC_W = 8;

  // Line positions on the data/address lines
  localparam int LANE_SEL_BIT = 0;
  localparam int PAR_ERR_BIT = 16;
  localparam int PAR_EN_BIT = 17;

  // Bus times as printed, in ns
  localparam int ADDR_SETUP_NS = 75;
  localparam int ADDR_HOLD_NS = 25;
  localparam int IN_STROBE_DELAY_NS = 100;
  localparam int REPLY_DESKEW_NS = 200;
  localparam int IN_STROBE_HOLD_NS = 150;
  localparam int SYNC_OFF_MIN_NS = 200;
  localparam int REPLY_TO_SYNC_NS = 300;
  localparam int WR_DATA_DELAY_NS = 100;
  localparam int OUT_STROBE_SETUP_NS = 100;
  localparam int OUT_STROBE_HOLD_NS = 150;
  localparam int WR_DATA_HOLD_NS = 100;
  localparam int SYNC_AFTER_OUT_NS = 175;
  localparam int RMW_GAP_NS = 200;
  localparam int REPLY_TIMEOUT_NS = 10000;

  // Least times round up to whole cycles
  localparam cnt_t ADDR_SETUP_CYC = cnt_t'((ADDR_SETUP_NS + CLK_NS - 1) / CLK_NS);
  localparam cnt_t ADDR_HOLD_CYC = cnt_t'((ADDR_HOLD_NS + CLK_NS - 1) / CLK_NS);
  localparam cnt_t IN_STROBE_DELAY_CYC =
    cnt_t'((IN_STROBE_DELAY_NS + CLK_NS - 1) / CLK_NS);
  localparam cnt_t REPLY_DESKEW_CYC =
    cnt_t'((REPLY_DESKEW_NS + CLK_NS - 1) / CLK_NS);
  localparam cnt_t IN_STROBE_HOLD_CYC =
    cnt_t'((IN_STROBE_HOLD_NS + CLK_NS - 1) / CLK_NS);
  localparam cnt_t SYNC_OFF_MIN_CYC =
    cnt_t'((SYNC_OFF_MIN_NS + CLK_NS - 1) / CLK_NS);
  localparam cnt_t REPLY_TO_SYNC_CYC =
    cnt_t'((REPLY_TO_SYNC_NS + CLK_NS - 1) / CLK_NS);
  localparam cnt_t WR_DATA_DELAY_CYC =
    cnt_t'((WR_DATA_DELAY_NS + CLK_NS - 1) / CLK_NS);
  localparam cnt_t OUT_STROBE_SETUP_CYC =
    cnt_t'((OUT_STROBE_SETUP_NS + CLK_NS - 1) / CLK_NS);
  localparam cnt_t OUT_STROBE_HOLD_CYC =
    cnt_t'((OUT_STROBE_HOLD_NS + CLK_NS - 1) / CLK_NS);
  localparam cnt_t WR_DATA_HOLD_CYC =
    cnt_t'((WR_DATA_HOLD_NS + CLK_NS - 1) / CLK_NS);
  localparam cnt_t SYNC_AFTER_OUT_CYC =
    cnt_t'((SYNC_AFTER_OUT_NS + CLK_NS - 1) / CLK_NS);
  localparam cnt_t RMW_GAP_CYC = cnt_t'((RMW_GAP_NS + CLK_NS - 1) / CLK_NS);
  localparam cnt_t REPLY_TIMEOUT_CYC = cnt_t'(REPLY_TIMEOUT_NS / CLK_NS);

  // Trap vectors (octal 114 and 4)
  localparam logic [VEC_W-1:0] VEC_NONE = 8'h00;
  localparam logic [VEC_W-1:0] VEC_PARITY = 8'h4c;
  localparam logic [VEC_W-1:0] VEC_TIMEOUT = 8'h04;

  // Kinds of bus cycle the core may ask for
  typedef enum logic [2:0] {
    WORD_READ_CYCLE,
    WORD_WRITE_CYCLE,
    BYTE_WRITE_CYCLE,
    READ_MODIFY_WRITE_CYCLE,
    READ_MODIFY_WRITE_BYTE_CYCLE
  } kind_t;

endpackage

// >>> verilog/elapsed_counter.sv
`timescale 1ns/100ps
module elapsed_counter #(
  parameter int WIDTH = 12
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Start counting again from zero
  input wire logic restart,
  // Cycles since the last restart, held at the top
  output logic [WIDTH-1:0] count_r
);

  // Saturate so a long idle never wraps back below a gap figure
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      count_r <= '0;
    else if (restart)
      count_r <= '0;
    else if (count_r != '1)
      count_r <= count_r + WIDTH'(1);
  end

endmodule

// >>> verilog/bus_cycle_master.sv
// Operation
// - Address, page select, write flag lead sync
// - Hold address after sync; sync whole cycle
// - Write flag picks write or read kind
// - Input strobe no sooner than 100 ns
// - Sample all eighteen lines after deskew
// - Drop input strobe 150 ns to 2 us
// - Slave drops reply, then master drops sync
// - Sync off 200 ns, 300 ns after reply
// - Continuous sync keeps slave; reply may stall
// - Write data and word flag after 100 ns
// - Lowest address bit selects byte lane
// - Line 16 forces wrong parity on writes; 17 unused
// - Output strobe after data; 10 us reply
// - Hold output strobe 150 ns, data 100 ns
// - Sync drops 175 ns after output strobe
// - Read-modify-write under one sync, 200 ns gap
// - Both parity lines asserted trap to 114
// - No reply in 10 us traps to 4
// - All lines active low, open drain
`timescale 1ns/100ps
module bus_cycle_master (
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic RESET_N,
  // Cycle request from the processor core
  input wire logic REQ_VALID,
  output logic REQ_READY,
  input wire bus_cycle_pkg::kind_t REQ_KIND,
  input wire logic [bus_cycle_pkg::DAL_W-1:0] REQ_ADDR,
  input wire logic REQ_IO_PAGE,
  input wire logic [bus_cycle_pkg::WORD_W-1:0] REQ_WDATA,
  input wire logic REQ_BAD_PARITY,
  // Answer to the processor core
  output logic RSP_VALID,
  output logic [bus_cycle_pkg::WORD_W-1:0] RSP_RDATA,
  output logic RSP_MODIFY,
  output logic RSP_TRAP,
  output logic [bus_cycle_pkg::VEC_W-1:0] RSP_VECTOR,
  // Mastership from the arbiter
  input wire logic BUS_GRANT,
  // Bus strobes, open drain
  input wire logic SYNC_STROBE_IN,
  output logic SYNC_STROBE_OUT,
  output logic SYNC_STROBE_OE_N,
  output logic DATA_INPUT_STROBE_OUT,
  output logic DATA_INPUT_STROBE_OE_N,
  output logic DATA_OUTPUT_STROBE_OUT,
  output logic DATA_OUTPUT_STROBE_OE_N,
  input wire logic SLAVE_REPLY_IN,
  // Bus control lines, open drain
  output logic WRITE_BYTE_CONTROL_OUT,
  output logic WRITE_BYTE_CONTROL_OE_N,
  output logic IO_PAGE_SELECT_OUT,
  output logic IO_PAGE_SELECT_OE_N,
  // Data/address lines, open drain
  input wire logic [bus_cycle_pkg::DAL_W-1:0] DATA_ADDRESS_LINES_IN,
  output logic [bus_cycle_pkg::DAL_W-1:0] DATA_ADDRESS_LINES_OUT,
  output logic [bus_cycle_pkg::DAL_W-1:0] DATA_ADDRESS_LINES_OE_N
);

  typedef enum {
    ST_IDLE,
    ST_GAP,
    ST_ADDR_SETUP,
    ST_ADDR_HOLD,
    ST_RD_STROBE,
    ST_RD_REPLY,
    ST_RD_DESKEW,
    ST_RD_END,
    ST_MOD_WAIT,
    ST_WR_SETUP,
    ST_WR_DATA,
    ST_WR_REPLY,
    ST_WR_HOLD,
    ST_WR_TAIL,
    ST_FINISH
  } state_t;

  state_t state_r;
  state_t state_nxt;
  bus_cycle_pkg::kind_t kind_r;
  logic [bus_cycle_pkg::DAL_W-1:0] addr_r;
  logic io_page_r;
  logic [bus_cycle_pkg::WORD_W-1:0] wdata_r;
  logic bad_par_r;
  logic trap_r;
  logic [bus_cycle_pkg::VEC_W-1:0] vector_r;
  logic sync_n_r;
  logic in_strobe_n_r;
  logic out_strobe_n_r;
  logic wtbt_n_r;
  logic bs7_n_r;
  logic [bus_cycle_pkg::DAL_W-1:0] dal_n_r;
  logic ready_r;
  logic rsp_valid_r;
  logic [bus_cycle_pkg::WORD_W-1:0] rdata_r;
  logic modify_r;
  logic [bus_cycle_pkg::VEC_W-1:0] rsp_vec_r;
  bus_cycle_pkg::cnt_t t_state;
  bus_cycle_pkg::cnt_t t_sync_on;
  bus_cycle_pkg::cnt_t t_sync_off;
  bus_cycle_pkg::cnt_t t_reply_off;
  logic taken;
  logic reply;
  logic bus_free;
  logic par_trap;
  logic timed_out;

  // Kind decoding used by both the sequencer and the line drivers
  function automatic logic is_write(input bus_cycle_pkg::kind_t k);
    is_write = (k == bus_cycle_pkg::WORD_WRITE_CYCLE) ||
               (k == bus_cycle_pkg::BYTE_WRITE_CYCLE);
  endfunction

  function automatic logic is_rmw(input bus_cycle_pkg::kind_t k);
    is_rmw = (k == bus_cycle_pkg::READ_MODIFY_WRITE_CYCLE) ||
             (k == bus_cycle_pkg::READ_MODIFY_WRITE_BYTE_CYCLE);
  endfunction

  function automatic logic is_byte(input bus_cycle_pkg::kind_t k);
    is_byte = (k == bus_cycle_pkg::BYTE_WRITE_CYCLE) ||
              (k == bus_cycle_pkg::READ_MODIFY_WRITE_BYTE_CYCLE);
  endfunction

  // Lines are asserted low; inputs are read as asserted when low
  assign reply = !SLAVE_REPLY_IN;
  assign taken = REQ_VALID && ready_r;
  assign timed_out = t_state >= bus_cycle_pkg::REPLY_TIMEOUT_CYC;
  // Both parity lines asserted at sampling time means a trap
  assign par_trap = !DATA_ADDRESS_LINES_IN[bus_cycle_pkg::PAR_ERR_BIT] &&
                    !DATA_ADDRESS_LINES_IN[bus_cycle_pkg::PAR_EN_BIT];
  // Previous cycle over, sync rested long enough, granted
  assign bus_free = BUS_GRANT && SYNC_STROBE_IN &&
                    (t_sync_off >= bus_cycle_pkg::SYNC_OFF_MIN_CYC) &&
                    (t_reply_off >= bus_cycle_pkg::REPLY_TO_SYNC_CYC);

  // Interval timers: time in state, since sync on, sync off, reply off
  elapsed_counter #(.WIDTH(bus_cycle_pkg::CNT_W)) u_t_state (
    .clk(CLK_SYS),
    .reset_n(RESET_N),
    .restart(state_r != state_nxt),
    .count_r(t_state)
  );

  elapsed_counter #(.WIDTH(bus_cycle_pkg::CNT_W)) u_t_sync_on (
    .clk(CLK_SYS),
    .reset_n(RESET_N),
    .restart(sync_n_r),
    .count_r(t_sync_on)
  );

  // Watches the bus line so another master's cycle also counts
  elapsed_counter #(.WIDTH(bus_cycle_pkg::CNT_W)) u_t_sync_off (
    .clk(CLK_SYS),
    .reset_n(RESET_N),
    .restart(!SYNC_STROBE_IN),
    .count_r(t_sync_off)
  );

  elapsed_counter #(.WIDTH(bus_cycle_pkg::CNT_W)) u_t_reply_off (
    .clk(CLK_SYS),
    .reset_n(RESET_N),
    .restart(reply),
    .count_r(t_reply_off)
  );

  // Cycle sequencer
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE:
        if (taken)
          state_nxt = ST_GAP;
      ST_GAP:
        if (bus_free)
          state_nxt = ST_ADDR_SETUP;
      ST_ADDR_SETUP:
        if (t_state >= bus_cycle_pkg::ADDR_SETUP_CYC)
          state_nxt = ST_ADDR_HOLD;
      ST_ADDR_HOLD:
        if (t_state >= bus_cycle_pkg::ADDR_HOLD_CYC)
          state_nxt = is_write(kind_r) ? ST_WR_SETUP : ST_RD_STROBE;
      ST_RD_STROBE:
        if (t_sync_on >= bus_cycle_pkg::IN_STROBE_DELAY_CYC)
          state_nxt = ST_RD_REPLY;
      ST_RD_REPLY:
        if (reply)
          state_nxt = ST_RD_DESKEW;
        else if (timed_out)
          state_nxt = ST_FINISH;
      ST_RD_DESKEW:
        if (t_state >= bus_cycle_pkg::REPLY_DESKEW_CYC &&
            t_state >= bus_cycle_pkg::IN_STROBE_HOLD_CYC)
          state_nxt = ST_RD_END;
      ST_RD_END:
        // A slow slave holding reply keeps sync on here
        if (!reply)
          state_nxt = (is_rmw(kind_r) && !trap_r) ? ST_MOD_WAIT
                                                  : ST_FINISH;
      ST_MOD_WAIT:
        if (taken)
          state_nxt = ST_WR_SETUP;
      ST_WR_SETUP:
        if (t_sync_on >= bus_cycle_pkg::WR_DATA_DELAY_CYC)
          state_nxt = ST_WR_DATA;
      ST_WR_DATA:
        if (t_state >= bus_cycle_pkg::OUT_STROBE_SETUP_CYC &&
            t_reply_off >= bus_cycle_pkg::RMW_GAP_CYC)
          state_nxt = ST_WR_REPLY;
      ST_WR_REPLY:
        if (reply)
          state_nxt = ST_WR_HOLD;
        else if (timed_out)
          state_nxt = ST_FINISH;
      ST_WR_HOLD:
        if (t_state >= bus_cycle_pkg::OUT_STROBE_HOLD_CYC)
          state_nxt = ST_WR_TAIL;
      ST_WR_TAIL:
        if (!reply && t_state >= bus_cycle_pkg::SYNC_AFTER_OUT_CYC)
          state_nxt = ST_FINISH;
      ST_FINISH:
        state_nxt = ST_IDLE;
      default:
        state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge CLK_SYS or negedge RESET_N)
  begin
    if (!RESET_N)
      state_r <= ST_IDLE;
    else
      state_r <= state_nxt;
  end

  // Request capture; the modify step only replaces the write data and bad-parity flag
  always_ff @(posedge CLK_SYS or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      kind_r <= bus_cycle_pkg::WORD_READ_CYCLE;
      addr_r <= '0;
      io_page_r <= 1'b0;
      wdata_r <= '0;
      bad_par_r <= 1'b0;
    end
    else if (taken)
    begin
      if (state_r == ST_IDLE)
      begin
        kind_r <= REQ_KIND;
        addr_r <= REQ_ADDR;
        io_page_r <= REQ_IO_PAGE;
      end
      wdata_r <= REQ_WDATA;
      bad_par_r <= REQ_BAD_PARITY;
    end
  end

  // Trap cause, decided on the sampling edge or on timeout
  always_ff @(posedge CLK_SYS or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      trap_r <= 1'b0;
      vector_r <= bus_cycle_pkg::VEC_NONE;
    end
    else if (state_r == ST_GAP)
    begin
      trap_r <= 1'b0;
      vector_r <= bus_cycle_pkg::VEC_NONE;
    end
    else if (state_r == ST_RD_DESKEW && state_nxt == ST_RD_END && par_trap)
    begin
      trap_r <= 1'b1;
      vector_r <= bus_cycle_pkg::VEC_PARITY;
    end
    else if ((state_r == ST_RD_REPLY || state_r == ST_WR_REPLY) &&
             state_nxt == ST_FINISH)
    begin
      trap_r <= 1'b1;
      vector_r <= bus_cycle_pkg::VEC_TIMEOUT;
    end
  end

  // Sync stays on from end of address setup to the finish, RMW included
  always_ff @(posedge CLK_SYS or negedge RESET_N)
  begin
    if (!RESET_N)
      sync_n_r <= 1'b1;
    else
      sync_n_r <= (state_nxt == ST_IDLE) || (state_nxt == ST_GAP) ||
                  (state_nxt == ST_ADDR_SETUP) ||
                  (state_nxt == ST_FINISH);
  end

  // Data strobes
  always_ff @(posedge CLK_SYS or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      in_strobe_n_r <= 1'b1;
      out_strobe_n_r <= 1'b1;
    end
    else
    begin
      in_strobe_n_r <= !((state_nxt == ST_RD_REPLY) ||
                         (state_nxt == ST_RD_DESKEW));
      out_strobe_n_r <= !((state_nxt == ST_WR_REPLY) ||
                          (state_nxt == ST_WR_HOLD));
    end
  end

  // Page select during addressing; write flag per phase and kind
  always_ff @(posedge CLK_SYS or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      bs7_n_r <= 1'b1;
      wtbt_n_r <= 1'b1;
    end
    else
    begin
      case (state_nxt)
        ST_ADDR_SETUP, ST_ADDR_HOLD:
        begin
          bs7_n_r <= !io_page_r;
          wtbt_n_r <= !is_write(kind_r);
        end
        ST_WR_DATA, ST_WR_REPLY, ST_WR_HOLD, ST_WR_TAIL:
        begin
          bs7_n_r <= 1'b1;
          wtbt_n_r <= !is_byte(kind_r);
        end
        ST_WR_SETUP:
        begin
          // Word writes must not drop the flag before 100 ns after sync
          bs7_n_r <= 1'b1;
          wtbt_n_r <= !is_write(kind_r);
        end
        default:
        begin
          bs7_n_r <= 1'b1;
          wtbt_n_r <= 1'b1;
        end
      endcase
    end
  end

  // Data/address lines: address, then write data; released for reads
  always_ff @(posedge CLK_SYS or negedge RESET_N)
  begin
    if (!RESET_N)
      dal_n_r <= '1;
    else
    begin
      case (state_nxt)
        ST_ADDR_SETUP, ST_ADDR_HOLD:
          dal_n_r <= ~addr_r;
        ST_WR_DATA, ST_WR_REPLY, ST_WR_HOLD:
          dal_n_r <= ~write_word();
        ST_WR_TAIL:
          if (state_r != ST_WR_TAIL ||
              t_state < bus_cycle_pkg::WR_DATA_HOLD_CYC)
            dal_n_r <= ~write_word();
          else
            dal_n_r <= '1;
        default:
          dal_n_r <= '1;
      endcase
    end
  end

  // Byte goes to the lane picked by the lowest address bit
  function automatic logic [bus_cycle_pkg::DAL_W-1:0] write_word();
    logic [bus_cycle_pkg::WORD_W-1:0] lanes;
    lanes = wdata_r;
    if (is_byte(kind_r))
      lanes = addr_r[bus_cycle_pkg::LANE_SEL_BIT]
              ? {wdata_r[bus_cycle_pkg::BYTE_W-1:0],
                 {bus_cycle_pkg::BYTE_W{1'b0}}}
              : {{bus_cycle_pkg::BYTE_W{1'b0}},
                 wdata_r[bus_cycle_pkg::BYTE_W-1:0]};
    // Upper line unused in writes; the next one forces bad parity
    write_word = {1'b0, bad_par_r, lanes};
  endfunction

  // Core handshake and answer
  always_ff @(posedge CLK_SYS or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      ready_r <= 1'b0;
      rsp_valid_r <= 1'b0;
      rdata_r <= '0;
      modify_r <= 1'b0;
      rsp_vec_r <= bus_cycle_pkg::VEC_NONE;
    end
    else
    begin
      ready_r <= (state_nxt == ST_IDLE) || (state_nxt == ST_MOD_WAIT);
      rsp_valid_r <= (state_r == ST_FINISH) ||
                     (state_r == ST_RD_END && state_nxt == ST_MOD_WAIT);
      modify_r <= (state_r == ST_RD_END && state_nxt == ST_MOD_WAIT);
      if (state_r == ST_RD_DESKEW && state_nxt == ST_RD_END)
        rdata_r <= ~DATA_ADDRESS_LINES_IN[bus_cycle_pkg::WORD_W-1:0];
      rsp_vec_r <= vector_r;
    end
  end

  // Pins: open drain, each line enabled exactly while pulled low
  assign SYNC_STROBE_OUT = sync_n_r;
  assign SYNC_STROBE_OE_N = sync_n_r;
  assign DATA_INPUT_STROBE_OUT = in_strobe_n_r;
  assign DATA_INPUT_STROBE_OE_N = in_strobe_n_r;
  assign DATA_OUTPUT_STROBE_OUT = out_strobe_n_r;
  assign DATA_OUTPUT_STROBE_OE_N = out_strobe_n_r;
  assign WRITE_BYTE_CONTROL_OUT = wtbt_n_r;
  assign WRITE_BYTE_CONTROL_OE_N = wtbt_n_r;
  assign IO_PAGE_SELECT_OUT = bs7_n_r;
  assign IO_PAGE_SELECT_OE_N = bs7_n_r;
  assign DATA_ADDRESS_LINES_OUT = dal_n_r;
  assign DATA_ADDRESS_LINES_OE_N = dal_n_r;
  assign REQ_READY = ready_r;
  assign RSP_VALID = rsp_valid_r;
  assign RSP_RDATA = rdata_r;
  assign RSP_MODIFY = modify_r;
  assign RSP_TRAP = rsp_valid_r && (rsp_vec_r != bus_cycle_pkg::VEC_NONE);
  assign RSP_VECTOR = rsp_valid_r ? rsp_vec_r : bus_cycle_pkg::VEC_NONE;

endmodule

// >>> verification/bus_cycle_master_chk.sv
`timescale 1ns/100ps
module bus_cycle_master_chk (
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic RESET_N,
  // Answer to the core
  input wire logic RSP_VALID,
  input wire logic RSP_TRAP,
  input wire logic [7:0] RSP_VECTOR,
  // Bus strobes and lines
  input wire logic SYNC_STROBE_IN,
  input wire logic SYNC_STROBE_OE_N,
  input wire logic DATA_INPUT_STROBE_OE_N,
  input wire logic DATA_OUTPUT_STROBE_OE_N,
  input wire logic SLAVE_REPLY_IN,
  input wire logic WRITE_BYTE_CONTROL_OE_N,
  input wire logic [17:0] DATA_ADDRESS_LINES_OE_N
);
  // Runs: 0 sync driven, 1 bus sync off, 2 reply on, 3 reply off,
  // 4 out-strobe off; they stop at the top so long idles never wrap
  logic [4:0][9:0] run_r;
  logic lane_r;
  logic [18:0] ctl;
  assign ctl = {WRITE_BYTE_CONTROL_OE_N, DATA_ADDRESS_LINES_OE_N};
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!RESET_N);

  function automatic logic [9:0] step(input logic go, input logic [9:0] c);
    return go ? (&c ? c : c + 10'h001) : 10'h000;
  endfunction

  // Interval counters, and the byte lane latched as sync goes low
  always_ff @(posedge CLK_SYS or negedge RESET_N)
    if (!RESET_N)
    begin
      run_r <= '0;
      lane_r <= 1'b0;
    end
    else
    begin
      run_r[0] <= step(!SYNC_STROBE_OE_N, run_r[0]);
      run_r[1] <= step(SYNC_STROBE_IN, run_r[1]);
      run_r[2] <= step(!SLAVE_REPLY_IN, run_r[2]);
      run_r[3] <= step(SLAVE_REPLY_IN, run_r[3]);
      run_r[4] <= step(DATA_OUTPUT_STROBE_OE_N, run_r[4]);
      if ($fell(SYNC_STROBE_OE_N))
        lane_r <= !DATA_ADDRESS_LINES_OE_N[0];
    end

  sequence addr_held;
    $stable(DATA_ADDRESS_LINES_OE_N) [*7];
  endsequence

  a_addr_setup: assert property (
    $fell(SYNC_STROBE_OE_N) |-> $past(ctl, 19) == ctl)
    else $error("Address moved too close to sync");
  a_addr_hold: assert property (
    $fell(SYNC_STROBE_OE_N) |-> addr_held)
    else $error("Address dropped too soon after sync");
  a_in_delay: assert property (
    $fell(DATA_INPUT_STROBE_OE_N) |-> run_r[0] >= 10'd25)
    else $error("Input strobe too early after sync");
  a_in_hold: assert property (
    $rose(DATA_INPUT_STROBE_OE_N) && !SLAVE_REPLY_IN
    |-> run_r[2] >= 10'd38 && run_r[2] <= 10'd500)
    else $error("Input strobe released outside its window");
  a_out_setup: assert property (
    $fell(DATA_OUTPUT_STROBE_OE_N)
    |-> $past(ctl, 25) == ctl && run_r[3] >= 10'd50)
    else $error("Output strobe too early");
  a_out_hold: assert property (
    $rose(DATA_OUTPUT_STROBE_OE_N) && !SLAVE_REPLY_IN |-> run_r[2] >= 10'd38)
    else $error("Output strobe released too soon");
  a_data_hold: assert property (
    $rose(DATA_OUTPUT_STROBE_OE_N) && !SLAVE_REPLY_IN
    |-> ##24 DATA_ADDRESS_LINES_OE_N == $past(DATA_ADDRESS_LINES_OE_N, 24))
    else $error("Write data removed too soon");
  a_sync_gap: assert property (
    $fell(SYNC_STROBE_OE_N) |-> run_r[1] >= 10'd50 && run_r[3] >= 10'd75)
    else $error("Sync reasserted too soon");
  a_sync_hold: assert property (
    !DATA_INPUT_STROBE_OE_N || !DATA_OUTPUT_STROBE_OE_N |-> !SYNC_STROBE_OE_N)
    else $error("Strobe without sync");
  a_sync_release: assert property (
    $rose(SYNC_STROBE_OE_N) && $past(DATA_OUTPUT_STROBE_OE_N)
    |-> SLAVE_REPLY_IN && run_r[4] >= 10'd44)
    else $error("Sync released too early");
  a_byte_lane: assert property (
    !DATA_OUTPUT_STROBE_OE_N && !WRITE_BYTE_CONTROL_OE_N
    |-> (lane_r ? &ctl[7:0] : &ctl[15:8]))
    else $error("Unused byte lane driven");
  a_trap_vector: assert property (
    RSP_TRAP |-> RSP_VALID && (RSP_VECTOR == 8'h4c || RSP_VECTOR == 8'h04))
    else $error("Trap without a trap vector");
endmodule
bind bus_cycle_master bus_cycle_master_chk i_chk (
  .CLK_SYS, .RESET_N, .RSP_VALID, .RSP_TRAP, .RSP_VECTOR, .SYNC_STROBE_IN,
  .SYNC_STROBE_OE_N, .DATA_INPUT_STROBE_OE_N, .DATA_OUTPUT_STROBE_OE_N,
  .SLAVE_REPLY_IN, .WRITE_BYTE_CONTROL_OE_N, .DATA_ADDRESS_LINES_OE_N
);

// >>> verification/bus_slave_model.sv
`timescale 1ns/100ps
module bus_slave_model (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Wire levels, low is asserted
  input wire logic sync_n,
  input wire logic din_n,
  input wire logic dout_n,
  input wire logic wtbt_n,
  input wire logic bs7_n,
  input wire logic [17:0] dal_n,
  // What this slave pulls, high is released to the pull-up
  output logic rply_n,
  output logic [17:0] drv_n,
  // Stall length, silence, and {enable, error} parity lines
  input wire logic [7:0] dly,
  input wire logic mute,
  input wire logic [1:0] par,
  // Last cycle as the slave saw it
  output logic [17:0] adr_r,
  output logic bs7_r,
  output logic bad_r
);
  logic [15:0] mem_r [16];
  logic [7:0] cnt_r;
  logic out_r;
  logic [17:0] w;
  assign w = ~dal_n;

  // Address, page select latched on the falling sync
  always_ff @(posedge clk)
    if ($fell(sync_n))
    begin
      adr_r <= w;
      bs7_r <= !bs7_n;
    end

  // Reply engine; reply falls before data leaves so the master sees order
  always_ff @(posedge clk or negedge reset_n)
    if (!reset_n)
    begin
      rply_n <= 1'b1;
      drv_n <= '1;
      cnt_r <= 8'h00;
      out_r <= 1'b0;
      bad_r <= 1'b0;
      mem_r <= '{default: 16'h0000};
    end
    else if (!rply_n && din_n && dout_n)
    begin
      rply_n <= 1'b1;
      if (out_r)
      begin
        bad_r <= w[16];
        if (wtbt_n)
          mem_r[adr_r[4:1]] <= w[15:0];
        else if (adr_r[0])
          mem_r[adr_r[4:1]][15:8] <= w[15:8];
        else
          mem_r[adr_r[4:1]][7:0] <= w[7:0];
      end
    end
    else if (din_n && dout_n)
    begin
      drv_n <= '1;
      cnt_r <= 8'h00;
    end
    else if (rply_n && !mute && cnt_r == dly)
    begin
      rply_n <= 1'b0;
      out_r <= !dout_n;
      if (!din_n)
        drv_n <= ~{par, mem_r[adr_r[4:1]]};
    end
    else if (rply_n)
      cnt_r <= cnt_r + 8'h01;
endmodule

// >>> verification/bus_cycle_master_test.sv
`timescale 1ns/100ps
`define CHK(a, b) \
  begin \
    comparisons++; \
    if ((a) !== (b)) \
    begin \
      n_fail++; \
      $display("BAD %0t got %h want %h", $time, (a), (b)); \
    end \
  end
module bus_cycle_master_test;
  logic clk = 1'b0, rst_n = 1'b0, grant = 1'b1;
  logic req_valid = 1'b0, req_io = 1'b0, req_bad = 1'b0, mute = 1'b0;
  bus_cycle_pkg::kind_t req_kind = bus_cycle_pkg::WORD_READ_CYCLE;
  logic [17:0] req_addr = 18'h00000, dal_o, dal_e, drv_n, adr_seen;
  logic [15:0] req_wdata = 16'h0000, rsp_rdata;
  logic [15:0] ref_mem [16] = '{default: 16'h0000};
  logic [7:0] rsp_vector, dly = 8'h00;
  logic [1:0] par = 2'b00;
  logic [31:0] seed = 32'h0000001f;
  logic req_ready, rsp_valid, rsp_modify, rsp_trap, rply_n, bs7_seen;
  logic bad_seen, sync_o, sync_e, din_o, din_e, dout_o, dout_e;
  logic wt_o, wt_e, io_o, io_e;
  int n_fail = 0;
  int comparisons = 0;
  // Open-drain wires: a released driver reads as the pull-up
  wire [17:0] dal_w = (dal_o | dal_e) & drv_n;

  bus_cycle_master i_dut (
    .CLK_SYS(clk), .RESET_N(rst_n),
    .REQ_VALID(req_valid), .REQ_READY(req_ready), .REQ_KIND(req_kind),
    .REQ_ADDR(req_addr), .REQ_IO_PAGE(req_io), .REQ_WDATA(req_wdata),
    .REQ_BAD_PARITY(req_bad), .RSP_VALID(rsp_valid), .RSP_RDATA(rsp_rdata),
    .RSP_MODIFY(rsp_modify), .RSP_TRAP(rsp_trap), .RSP_VECTOR(rsp_vector),
    .BUS_GRANT(grant), .SYNC_STROBE_IN(sync_o | sync_e),
    .SYNC_STROBE_OUT(sync_o), .SYNC_STROBE_OE_N(sync_e),
    .DATA_INPUT_STROBE_OUT(din_o), .DATA_INPUT_STROBE_OE_N(din_e),
    .DATA_OUTPUT_STROBE_OUT(dout_o), .DATA_OUTPUT_STROBE_OE_N(dout_e),
    .SLAVE_REPLY_IN(rply_n), .WRITE_BYTE_CONTROL_OUT(wt_o),
    .WRITE_BYTE_CONTROL_OE_N(wt_e), .IO_PAGE_SELECT_OUT(io_o),
    .IO_PAGE_SELECT_OE_N(io_e), .DATA_ADDRESS_LINES_IN(dal_w),
    .DATA_ADDRESS_LINES_OUT(dal_o), .DATA_ADDRESS_LINES_OE_N(dal_e)
  );
  bus_slave_model i_slave (
    .clk(clk), .reset_n(rst_n), .sync_n(sync_o | sync_e),
    .din_n(din_o | din_e), .dout_n(dout_o | dout_e), .wtbt_n(wt_o | wt_e),
    .bs7_n(io_o | io_e), .dal_n(dal_w), .rply_n(rply_n), .drv_n(drv_n),
    .dly(dly), .mute(mute), .par(par), .adr_r(adr_seen), .bs7_r(bs7_seen),
    .bad_r(bad_seen)
  );

  always #2 clk = ~clk;

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task report_and_stop;
    $display("Totals: %0d comparisons, %0d mismatches", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // One request, held from a falling edge until taken, then its answer
  task automatic offer(input bus_cycle_pkg::kind_t k, input logic [17:0] a,
    input logic io, input logic [15:0] wd, input logic bp);
    int n;
    for (n = 0; n < 9000 && req_ready !== 1'b1; n++)
      @(negedge clk);
    // A core port that never opens is a hang, not a pass
    if (n == 9000)
    begin
      n_fail++;
      report_and_stop();
    end
    req_valid = 1'b1;
    req_kind = k;
    req_addr = a;
    req_io = io;
    req_wdata = wd;
    req_bad = bp;
    @(negedge clk);
    req_valid = 1'b0;
    for (n = 0; n < 9000 && rsp_valid !== 1'b1; n++)
      @(negedge clk);
    if (n == 9000)
    begin
      n_fail++;
      report_and_stop();
    end
  endtask

  // Whole bus cycle, checked against the reference memory
  task automatic cyc(input bus_cycle_pkg::kind_t k, input logic [17:0] a,
    input logic io, input logic [15:0] wd, input logic bp);
    int ki;
    logic trap;
    logic [7:0] vec;
    logic [15:0] old;
    ki = int'(k);
    old = ref_mem[a[4:1]];
    trap = mute || (ki != 1 && ki != 2 && &par);
    vec = mute ? 8'h04 : (trap ? 8'h4c : 8'h00);
    offer(k, a, io, wd, bp);
    `CHK(rsp_trap, trap)
    `CHK(rsp_vector, vec)
    `CHK(rsp_modify, ki > 2 && !trap)
    `CHK({bs7_seen, adr_seen}, {io, a})
    if (!mute && ki != 1 && ki != 2)
      `CHK(rsp_rdata, old)
    if (ki > 2 && !trap)
      offer(k, a, io, wd, bp);
    if (ki > 0 && !trap)
    begin
      `CHK(bad_seen, bp)
      if (ki == 1 || ki == 3)
        ref_mem[a[4:1]] = wd;
      else if (a[0])
        ref_mem[a[4:1]][15:8] = wd[7:0];
      else
        ref_mem[a[4:1]][7:0] = wd[7:0];
    end
  endtask

  initial
  begin
    repeat (12) @(negedge clk);
    rst_n = 1'b1;
    // Every kind, both lanes, parity states and slave stalls, mixed
    for (int i = 0; i < 40; i++)
    begin
      seed = lfsr(seed);
      par = seed[1:0];
      dly = {2'b00, seed[7:2]};
      seed = lfsr(seed);
      cyc(bus_cycle_pkg::kind_t'(i % 5), seed[17:0], seed[18], seed[31:16],
        seed[19]);
    end
    par = 2'b00;
    // Read back every word so lost or misplaced writes show up
    for (int j = 0; j < 16; j++)
      cyc(bus_cycle_pkg::WORD_READ_CYCLE, 18'(j * 2), 1'b0, 16'h0000, 1'b0);
    $display("Test mixed traffic done");
    // Silent slave on a read and a byte write, then a normal read
    mute = 1'b1;
    cyc(bus_cycle_pkg::WORD_READ_CYCLE, 18'h00004, 1'b1, 16'h0000, 1'b0);
    cyc(bus_cycle_pkg::BYTE_WRITE_CYCLE, 18'h00003, 1'b0, 16'h00a5, 1'b0);
    mute = 1'b0;
    cyc(bus_cycle_pkg::WORD_READ_CYCLE, 18'h00002, 1'b0, 16'h0000, 1'b0);
    $display("Test reply timeout done");
    report_and_stop();
  end
endmodule
